// ---- smcg_map.svh ----
// constants for the sleep mode clock gating block
`ifndef SMCG_MAP_SVH
`define SMCG_MAP_SVH
`define SMCG_MODE_IDLE     3'h0
`define SMCG_MODE_PWRDN    3'h2
`define SMCG_MODE_PWRSAVE  3'h3
`define SMCG_MODE_ADCNR    3'h1
`define SMCG_MODE_STANDBY  3'h6
`define SMCG_MODE_EXTSTBY  3'h7
`define SMCG_EN_RESET      8'hFF
`define SMCG_BIT_CPU       0
`define SMCG_BIT_SRAM      1
`define SMCG_BIT_TIMER     2
`define SMCG_BIT_SPI       3
`define SMCG_BIT_IRQ       4
`define SMCG_BIT_ATIMER    5
`define SMCG_BIT_ADC       6
`define SMCG_BIT_OSC       7
`endif

// ---- smcg_pkg.sv ----
// types for the sleep mode clock gating block
package smcg_pkg;
    typedef enum logic [1:0] {
        SMCG_RUN   = 2'b00,
        SMCG_SLEEP = 2'b01
    } smcg_state_t;
endpackage

// ---- smcg_top.sv ----
// sleep mode controller that gates the clock domains per mode
// Notes on behaviour
// - six selectable sleep modes, each chosen by its own mode code
// - idle stops cpu, asynchronous timer and adc; sram, timer, spi, interrupt logic keep running
// - power-down stops oscillator and all functions until interrupt or reset
// - power-save keeps the asynchronous timer running
// - adc noise reduction keeps asynchronous timer, adc, interrupt logic and oscillator running
// - standby keeps the main oscillator running, all else sleeps
// - extended standby keeps main oscillator and asynchronous timer running
`include "smcg_map.svh"
module smcg_top (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       sleep_req,
    input  wire logic [2:0] sleep_mode,
    input  wire logic       wake_irq,
    output logic [7:0]      domain_en,
    output logic            sleeping,
    output logic            mode_err
);
    ////////////////////////////////////////////////////////////////////////
    // wake request passes a two stage synchroniser
    logic wake_s1;
    logic wake_s2;
    logic next_wake_s1;
    logic next_wake_s2;

    always_comb begin
        next_wake_s1 = wake_irq;
        next_wake_s2 = wake_s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            wake_s1 <= next_wake_s1;
            wake_s2 <= next_wake_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enable pattern for a mode, bit set means domain stays clocked
    function automatic logic [7:0] smcg_mode_en(input logic [2:0] m);
        logic [7:0] e;
        e = 8'h00;
        case (m)
            `SMCG_MODE_IDLE: begin
                e = `SMCG_EN_RESET;
                e[`SMCG_BIT_CPU]    = 1'b0;
                e[`SMCG_BIT_ATIMER] = 1'b0;
                e[`SMCG_BIT_ADC]    = 1'b0;
            end
            `SMCG_MODE_PWRDN: begin
                e = 8'h00;
            end
            `SMCG_MODE_PWRSAVE: begin
                e[`SMCG_BIT_ATIMER] = 1'b1;
            end
            `SMCG_MODE_ADCNR: begin
                e[`SMCG_BIT_ATIMER] = 1'b1;
                e[`SMCG_BIT_ADC]    = 1'b1;
                e[`SMCG_BIT_OSC]    = 1'b1;
                e[`SMCG_BIT_IRQ]    = 1'b1;
            end
            `SMCG_MODE_STANDBY: begin
                e[`SMCG_BIT_OSC] = 1'b1;
            end
            `SMCG_MODE_EXTSTBY: begin
                e[`SMCG_BIT_OSC]    = 1'b1;
                e[`SMCG_BIT_ATIMER] = 1'b1;
            end
            default: begin
                e = `SMCG_EN_RESET;
            end
        endcase
        return e;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sequencer state and next values
    smcg_pkg::smcg_state_t state;
    smcg_pkg::smcg_state_t next_state;
    logic [7:0]            next_domain_en;
    logic                  next_sleeping;
    logic                  next_mode_err;

    ////////////////////////////////////////////////////////////////////////
    // high for the six codes that select a sleep mode
    function automatic logic smcg_mode_ok(input logic [2:0] m);
        logic ok;
        ok = 1'b0;
        case (m)
            `SMCG_MODE_IDLE:    ok = 1'b1;
            `SMCG_MODE_ADCNR:   ok = 1'b1;
            `SMCG_MODE_PWRDN:   ok = 1'b1;
            `SMCG_MODE_PWRSAVE: ok = 1'b1;
            `SMCG_MODE_STANDBY: ok = 1'b1;
            `SMCG_MODE_EXTSTBY: ok = 1'b1;
            default:            ok = 1'b0;
        endcase
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state decode
    logic in_run;
    logic in_sleep;
    logic bad_state;

    always_comb begin
        in_run    = (state == smcg_pkg::SMCG_RUN);
        in_sleep  = (state == smcg_pkg::SMCG_SLEEP);
        bad_state = !in_run && !in_sleep;
    end

    ////////////////////////////////////////////////////////////////////////
    // request and wake decode
    logic [7:0] sel;
    logic       mode_ok;
    logic       req_taken;
    logic       req_good;
    logic       req_bad;
    logic       wake_taken;

    always_comb begin
        sel        = smcg_mode_en(sleep_mode);
        mode_ok    = smcg_mode_ok(sleep_mode);
        // a wake still in the synchroniser blocks a new request
        req_taken  = in_run && sleep_req && !wake_s2;
        req_good   = req_taken && mode_ok;
        req_bad    = req_taken && !mode_ok;
        wake_taken = in_sleep && wake_s2;
    end

    ////////////////////////////////////////////////////////////////////////
    // run and sleep sequencing
    always_comb begin
        next_state = state;
        case (state)
            smcg_pkg::SMCG_RUN: begin
                if (req_good) begin
                    next_state = smcg_pkg::SMCG_SLEEP;
                end
            end
            smcg_pkg::SMCG_SLEEP: begin
                if (wake_taken) begin
                    next_state = smcg_pkg::SMCG_RUN;
                end
            end
            default: begin
                next_state = smcg_pkg::SMCG_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= smcg_pkg::SMCG_RUN;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // domain clock enables, pattern held until the wake
    always_comb begin
        next_domain_en = domain_en;
        if (req_good) begin
            next_domain_en = sel;
        end else if (wake_taken || bad_state) begin
            next_domain_en = `SMCG_EN_RESET;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            domain_en <= `SMCG_EN_RESET;
        end else begin
            domain_en <= next_domain_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep flag seen by the core
    always_comb begin
        next_sleeping = sleeping;
        if (req_good) begin
            next_sleeping = 1'b1;
        end else if (wake_taken || bad_state) begin
            next_sleeping = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sleeping <= 1'b0;
        end else begin
            sleeping <= next_sleeping;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error flag for an unknown code, cleared by the next good request
    always_comb begin
        next_mode_err = mode_err;
        if (req_bad) begin
            next_mode_err = 1'b1;
        end else if (req_good) begin
            next_mode_err = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_err <= 1'b0;
        end else begin
            mode_err <= next_mode_err;
        end
    end
endmodule

// ---- smcg_wake_model.sv ----
// wake source model standing in for the interrupt side
module smcg_wake_model (
    input  wire logic clk,
    input  wire logic fire,
    input  wire logic sleeping,
    output logic      wake_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial wake_irq = 1'b0;
    // hold the wake request until the core runs again
    always @(posedge clk) wake_irq <= fire | (wake_irq & sleeping);
endmodule

// ---- smcg_properties.sv ----
// assertions for the sleep mode clock gating block
module smcg_chk (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       sleep_req,
    input wire logic [2:0] sleep_mode,
    input wire logic       wake_irq,
    input wire logic [7:0] domain_en,
    input wire logic       sleeping,
    input wire logic       mode_err
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
idle_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h0 && !$past(wake_irq, 2) |=> domain_en == 8'h9E)
    else $error("idle");
pwrdn_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h2 && !$past(wake_irq, 2) |=> domain_en == 8'h00)
    else $error("pwrdn");
save_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h3 && !$past(wake_irq, 2) |=> domain_en == 8'h20)
    else $error("save");
adcnr_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h1 && !$past(wake_irq, 2) |=> domain_en == 8'hF0)
    else $error("adcnr");
stby_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h6 && !$past(wake_irq, 2) |=> domain_en == 8'h80)
    else $error("stby");
xstby_en_a: assert property (!sleeping && sleep_req &&
    sleep_mode == 3'h7 && !$past(wake_irq, 2) |=> domain_en == 8'hA0)
    else $error("xstby");
bad_mode_a: assert property (!sleeping && sleep_req &&
    sleep_mode[2:1] == 2'h2 && !$past(wake_irq, 2)
    |=> mode_err && domain_en == 8'hFF) else $error("bad mode");
wake_up_a: assert property (sleeping && $rose(wake_irq) |->
    ##[1:4] (domain_en == 8'hFF && !sleeping)) else $error("wake");
endmodule
bind smcg_top smcg_chk u_chk (.clk(clk), .arst_n(arst_n),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_irq(wake_irq),
    .domain_en(domain_en), .sleeping(sleeping), .mode_err(mode_err));

// ---- tb_smcg_top.sv ----
// testbench for the sleep mode clock gating block
`include "smcg_map.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_smcg_top;
timeunit 1ns;
timeprecision 1ps;
logic       clk = 0, arst_n = 0, sleep_req = 0, fire = 0;
logic [2:0] sleep_mode = 3'h0;
logic [7:0] domain_en;
logic       wake_irq, sleeping, mode_err;
int         bad_count = 0, cmp_count = 0;
always #2.5 clk = ~clk;
smcg_top u_dut (.clk(clk), .arst_n(arst_n), .sleep_req(sleep_req),
    .sleep_mode(sleep_mode), .wake_irq(wake_irq), .domain_en(domain_en),
    .sleeping(sleeping), .mode_err(mode_err));
smcg_wake_model u_wake (.clk(clk), .fire(fire), .sleeping(sleeping),
    .wake_irq(wake_irq));
task automatic req(input logic [2:0] m);
    @(negedge clk) sleep_req = 1; sleep_mode = m;
    @(negedge clk) sleep_req = 0;
endtask
task automatic wake();
    int n;
    @(negedge clk) fire = 1;
    @(negedge clk) fire = 0;
    for (n = 0; n < 8 && sleeping !== 1'b0; n++) @(negedge clk);
    `CHK("woken", 8'hFF, domain_en)
    `CHK("awake", 1'b0, sleeping)
    repeat (4) @(negedge clk);
endtask
task automatic t_reset();
    `CHK("reset state", 10'h3FC, {domain_en, sleeping, mode_err})
    req(`SMCG_MODE_STANDBY);
    `CHK("standby", 8'h80, domain_en)
    @(negedge clk) arst_n = 0;
    @(negedge clk);
    `CHK("cut sleep", 10'h3FC, {domain_en, sleeping, mode_err})
    arst_n = 1;
    req(`SMCG_MODE_EXTSTBY);
    `CHK("after reset", 8'hA0, domain_en)
    wake();
    $display("test reset done");
endtask
task automatic t_modes();
    logic [2:0] m[6] = '{`SMCG_MODE_IDLE, `SMCG_MODE_ADCNR, `SMCG_MODE_PWRDN,
        `SMCG_MODE_PWRSAVE, `SMCG_MODE_STANDBY, `SMCG_MODE_EXTSTBY};
    logic [7:0] e[6] = '{8'h9E, 8'hF0, 8'h00, 8'h20, 8'h80, 8'hA0};
    for (int i = 0; i < 6; i++) begin
        req(m[i]);
        `CHK("pattern", e[i], domain_en)
        `CHK("asleep", 1'b1, sleeping)
        repeat (3) @(negedge clk);
        `CHK("held", e[i], domain_en)
        wake();
    end
    $display("test modes done");
endtask
task automatic t_bad();
    req(3'h4);
    req(3'h5);
    `CHK("bad mode", 2'h3, {mode_err, domain_en[0]})
    req(`SMCG_MODE_PWRDN);
    `CHK("cleared", 1'b0, mode_err)
    req(`SMCG_MODE_IDLE);
    `CHK("ignored", 8'h00, domain_en)
    wake();
    $display("test bad and ignored done");
endtask
task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
initial begin
    #20000 bad_count++;
    summarize();
end
initial begin
    repeat (16) @(negedge clk);
    arst_n = 1;
    t_reset();
    t_modes();
    t_bad();
    summarize();
end
endmodule
